// ==== rtl/pcse_cr_merge.sv ====
// Field-masked merge of the condition register.
// Assumes mask bit 7 steers field 0 (bits 31:28), mask bit 0 steers field 7.
`timescale 1ns/1ns
module pcse_cr_merge (
  input  wire logic [31:0] i_cr,
  input  wire logic [31:0] i_src,
  input  wire logic [7:0]  i_mask,
  output logic      [31:0] o_cr
);
  // One 4-bit field per mask bit
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_fld
      assign o_cr[4*g +: 4] = i_mask[g] ? i_src[4*g +: 4] : i_cr[4*g +: 4]; // see [RULE5] see [RULE6]
    end
  endgenerate
endmodule

// ==== rtl/pcse_exec.sv ====
// What this block does
// [RULE1] Floating-point opcodes trap as illegal, raising the program interrupt.
// [RULE2] Exception-summary move copies summary bits 0:3 into the chosen condition field.
// [RULE3] That same move clears summary bits 0:3 to zero.
// [RULE4] Condition-register read writes all 32 bits into the destination register.
// [RULE5] Masked condition write carries 8-bit mask; top bit is field 0.
// [RULE6] Only fields whose mask bit is one load from the source register.
// [RULE7] Special-register read loads destination from the selected special register.
// [RULE8] Special-register write loads the selected register from the source register.
// [RULE9] Special register number is rebuilt from two swapped five-bit halves.
// [RULE10] I/O barrier: earlier loads and stores complete before later ones.
// [RULE11] Instruction synchronize waits for earlier instructions and blocks later ones.
// [RULE12] Instruction synchronize discards prefetched instructions for refetch.
// [RULE13] Instruction synchronize does not wait for memory ordering.
// [RULE14] Full synchronize waits for earlier instructions and blocks later ones.
// [RULE15] Full synchronize waits until memory accesses are complete system-wide.
// [RULE16] I/O barrier and full synchronize behave identically.
// File holds the execution unit top. Assumes the pipeline status and SPR file
// sit on the same clock, so their inputs need no synchronisers.
`timescale 1ns/1ns
module pcse_exec
  import pcse_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_source_gpr,
  input  wire logic [31:0] i_spr_rdata,
  input  wire logic        i_pipe_empty,
  input  wire logic        i_mem_idle,
  output logic             o_ready,
  output logic [31:0]      o_condition_register,
  output logic [31:0]      o_fixed_point_exception_reg,
  output logic             o_gpr_we,
  output logic [4:0]       o_gpr_addr,
  output logic [31:0]      o_gpr_wdata,
  output logic             o_spr_we,
  output logic [9:0]       o_spr_num,
  output logic [31:0]      o_spr_wdata,
  output logic             o_prog_int,
  output logic [15:0]      o_int_vector,
  output logic             o_flush_prefetch,
  output logic             o_sync_done
);
  logic [5:0]  opcode;
  logic [9:0]  xo;
  logic [2:0]  dest_cond_field;
  logic [7:0]  cond_field_mask;
  logic [9:0]  special_reg_number;
  logic        accept;
  logic        is_fp;
  logic        is_mcrxr;
  logic        is_mfcr;
  logic        is_mtcrf;
  logic        is_mfspr;
  logic        is_mtspr;
  logic        is_fullsync;
  logic        is_isync;
  logic [7:0]  merge_mask;
  logic [31:0] merge_src;
  logic [31:0] merged_cr;

  pcse_state_t state_r, state_nxt;
  logic        ready_r, ready_nxt;
  logic        mem_wait_r, mem_wait_nxt;
  logic [31:0] cr_r, cr_nxt;
  logic [31:0] xer_r, xer_nxt;
  logic        gpr_we_r, gpr_we_nxt;
  logic [4:0]  gpr_addr_r, gpr_addr_nxt;
  logic [31:0] gpr_wdata_r, gpr_wdata_nxt;
  logic        spr_we_r, spr_we_nxt;
  logic [9:0]  spr_num_r, spr_num_nxt;
  logic [31:0] spr_wdata_r, spr_wdata_nxt;
  logic        prog_r, prog_nxt;
  logic        flush_r, flush_nxt;
  logic        done_r, done_nxt;

  // Field extraction and decode
  assign opcode             = i_instr[PCSE_OP_MSB -: 6];
  assign xo                 = i_instr[PCSE_XO_MSB -: 10];
  assign dest_cond_field    = i_instr[PCSE_CRF_MSB -: 3];
  assign cond_field_mask    = i_instr[PCSE_CRM_MSB -: 8]; // see [RULE5]
  assign special_reg_number = {i_instr[PCSE_SPRB_MSB -: 5], i_instr[PCSE_SPRA_MSB -: 5]}; // see [RULE9]
  assign accept             = i_valid & ready_r;
  assign is_fp              = (opcode >= PCSE_OP_FPLS_LO && opcode <= PCSE_OP_FPLS_HI) ||
                              opcode == PCSE_OP_FPS || opcode == PCSE_OP_FPD; // see [RULE1]
  assign is_mcrxr           = opcode == PCSE_OP_EXT31 && xo == PCSE_XO_MCRXR;
  assign is_mfcr            = opcode == PCSE_OP_EXT31 && xo == PCSE_XO_MFCR;
  assign is_mtcrf           = opcode == PCSE_OP_EXT31 && xo == PCSE_XO_MTCRF;
  assign is_mfspr           = opcode == PCSE_OP_EXT31 && xo == PCSE_XO_MFSPR;
  assign is_mtspr           = opcode == PCSE_OP_EXT31 && xo == PCSE_XO_MTSPR;
  // Barrier and full sync share one decode, so they cannot drift apart
  assign is_fullsync        = opcode == PCSE_OP_EXT31 && (xo == PCSE_XO_IOBAR || xo == PCSE_XO_SYNC); // see [RULE16]
  assign is_isync           = opcode == PCSE_OP_EXT19 && xo == PCSE_XO_ISYNC;

  // One merger serves both the masked write and the summary copy
  assign merge_mask = is_mtcrf ? cond_field_mask : (8'h80 >> dest_cond_field); // see [RULE2]
  assign merge_src  = is_mtcrf ? i_source_gpr : {8{xer_r[PCSE_XER_SUM_MSB -: 4]}};

  pcse_cr_merge u_merge (
    .i_cr   (cr_r),
    .i_src  (merge_src),
    .i_mask (merge_mask),
    .o_cr   (merged_cr)
  );

  // Next-state logic for execution and the synchronizer sequence
  always_comb begin
    state_nxt     = state_r;
    mem_wait_nxt  = mem_wait_r;
    cr_nxt        = cr_r;
    xer_nxt       = xer_r;
    gpr_we_nxt    = 1'b0;
    gpr_addr_nxt  = gpr_addr_r;
    gpr_wdata_nxt = gpr_wdata_r;
    spr_we_nxt    = 1'b0;
    spr_num_nxt   = spr_num_r;
    spr_wdata_nxt = spr_wdata_r;
    prog_nxt      = 1'b0;
    flush_nxt     = 1'b0;
    done_nxt      = 1'b0;
    case (state_r)
      PCSE_IDLE: begin
        if (accept) begin
          if (is_fp) begin
            prog_nxt = 1'b1; // see [RULE1]
          end else if (is_mcrxr) begin
            cr_nxt = merged_cr; // see [RULE2]
            xer_nxt[PCSE_XER_SUM_MSB -: 4] = 4'h0; // see [RULE3]
          end else if (is_mfcr) begin
            gpr_we_nxt    = 1'b1;
            gpr_addr_nxt  = i_instr[PCSE_RD_MSB -: 5];
            gpr_wdata_nxt = cr_r; // see [RULE4]
          end else if (is_mtcrf) begin
            cr_nxt = merged_cr; // see [RULE6]
          end else if (is_mfspr) begin
            gpr_we_nxt    = 1'b1;
            gpr_addr_nxt  = i_instr[PCSE_RD_MSB -: 5];
            gpr_wdata_nxt = (special_reg_number == PCSE_SPR_XER) ? xer_r : i_spr_rdata; // see [RULE7]
          end else if (is_mtspr) begin
            // The exception register lives here; other numbers go to the SPR file
            if (special_reg_number == PCSE_SPR_XER) begin
              xer_nxt = i_source_gpr; // see [RULE8]
            end else begin
              spr_we_nxt    = 1'b1;
              spr_num_nxt   = special_reg_number;
              spr_wdata_nxt = i_source_gpr; // see [RULE8]
            end
          end else if (is_fullsync || is_isync) begin
            state_nxt    = PCSE_WAIT; // see [RULE11] see [RULE14]
            mem_wait_nxt = is_fullsync; // see [RULE13]
          end
        end
      end
      PCSE_WAIT: begin
        // Full sync also needs the memory system quiet toward other devices
        if (i_pipe_empty && (!mem_wait_r || i_mem_idle)) begin // see [RULE10] see [RULE15]
          if (mem_wait_r) begin
            state_nxt = PCSE_IDLE;
            done_nxt  = 1'b1;
          end else begin
            state_nxt = PCSE_FLUSH;
            flush_nxt = 1'b1; // see [RULE12]
          end
        end
      end
      PCSE_FLUSH: begin
        state_nxt = PCSE_IDLE;
        done_nxt  = 1'b1;
      end
      default: begin
        state_nxt = PCSE_IDLE;
      end
    endcase
    // Later instructions held off while a sync is in flight
    ready_nxt = (state_nxt == PCSE_IDLE); // see [RULE11] see [RULE14]
  end

  // State registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r     <= PCSE_IDLE;
      ready_r     <= 1'b1;
      mem_wait_r  <= 1'b0;
      cr_r        <= PCSE_CR_RESET;
      xer_r       <= PCSE_XER_RESET;
      gpr_we_r    <= 1'b0;
      gpr_addr_r  <= 5'h00;
      gpr_wdata_r <= 32'h0000_0000;
      spr_we_r    <= 1'b0;
      spr_num_r   <= 10'h000;
      spr_wdata_r <= 32'h0000_0000;
      prog_r      <= 1'b0;
      flush_r     <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ready_r     <= ready_nxt;
      mem_wait_r  <= mem_wait_nxt;
      cr_r        <= cr_nxt;
      xer_r       <= xer_nxt;
      gpr_we_r    <= gpr_we_nxt;
      gpr_addr_r  <= gpr_addr_nxt;
      gpr_wdata_r <= gpr_wdata_nxt;
      spr_we_r    <= spr_we_nxt;
      spr_num_r   <= spr_num_nxt;
      spr_wdata_r <= spr_wdata_nxt;
      prog_r      <= prog_nxt;
      flush_r     <= flush_nxt;
      done_r      <= done_nxt;
    end
  end

  // Outputs straight from flops, except the interrupt vector, which is the constant PCSE_VEC_PROG
  assign o_ready                     = ready_r;
  assign o_condition_register        = cr_r;
  assign o_fixed_point_exception_reg = xer_r;
  assign o_gpr_we                    = gpr_we_r;
  assign o_gpr_addr                  = gpr_addr_r;
  assign o_gpr_wdata                 = gpr_wdata_r;
  assign o_spr_we                    = spr_we_r;
  assign o_spr_num                   = spr_num_r;
  assign o_spr_wdata                 = spr_wdata_r;
  assign o_prog_int                  = prog_r;
  assign o_int_vector                = PCSE_VEC_PROG;
  assign o_flush_prefetch            = flush_r;
  assign o_sync_done                 = done_r;

  // Checks next to the logic they guard
  a_fp_trap_vec: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE1]
    accept && is_fp |=> o_prog_int && o_int_vector == PCSE_VEC_PROG && !o_gpr_we)
    else $error("float opcode did not trap");
  a_sum_copy_fld: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE2]
    accept && is_mcrxr |=> o_condition_register[{~$past(dest_cond_field), 2'b00} +: 4]
                           == $past(xer_r[PCSE_XER_SUM_MSB -: 4]))
    else $error("summary bits not copied to field");
  a_sum_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE3]
    accept && is_mcrxr |=> o_fixed_point_exception_reg[PCSE_XER_SUM_MSB -: 4] == 4'h0)
    else $error("summary bits not cleared");
  a_cr_read_all: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE4]
    accept && is_mfcr |=> o_gpr_we && o_gpr_wdata == $past(o_condition_register))
    else $error("condition read wrong");
  a_mask_zero_keep: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE6]
    accept && is_mtcrf && cond_field_mask == 8'h00 |=> $stable(o_condition_register))
    else $error("unmasked field changed");
  a_mask_top_fld: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE5]
    accept && is_mtcrf && cond_field_mask == 8'h80 |=>
      o_condition_register == {$past(i_source_gpr[31:28]), $past(o_condition_register[27:0])})
    else $error("top mask bit not field 0");
  a_spr_num_split: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE9]
    accept && is_mtspr && special_reg_number != PCSE_SPR_XER |=>
      o_spr_we && o_spr_num == {$past(i_instr[15:11]), $past(i_instr[20:16])}
      && o_spr_wdata == $past(i_source_gpr))
    else $error("special write number or data wrong");
  a_spr_read: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE7]
    accept && is_mfspr && special_reg_number != PCSE_SPR_XER |=> o_gpr_wdata == $past(i_spr_rdata))
    else $error("special read data wrong");
  a_sync_blocks: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE14]
    accept && (is_fullsync || is_isync) |=> !o_ready && !o_sync_done && state_r == PCSE_WAIT)
    else $error("later instruction accepted during sync");
  a_sync_mem_idle: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE15]
    o_sync_done && !$past(o_flush_prefetch) |-> $past(i_mem_idle) && $past(i_pipe_empty))
    else $error("full sync ended before memory idle");
  a_isync_no_mem: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE13]
    state_r == PCSE_WAIT && !mem_wait_r && i_pipe_empty && !i_mem_idle |=> o_flush_prefetch ##1 o_sync_done)
    else $error("isync waited on memory");
  a_flush_pipe: assert property (@(posedge i_mclk) disable iff (!i_resetn) // see [RULE12]
    o_flush_prefetch |-> $past(i_pipe_empty) && !o_ready ##1 o_sync_done && o_ready)
    else $error("flush out of order");
endmodule

// ==== rtl/pcse_pkg.sv ====
// Package for the processor-control and synchronizing execution unit.
// Assumes big-endian bit numbering in the architecture, mapped to [31:0] here.
package pcse_pkg;
  // Primary opcodes and extended opcodes
  localparam logic [5:0] PCSE_OP_EXT31   = 6'h1f;
  localparam logic [5:0] PCSE_OP_EXT19   = 6'h13;
  localparam logic [5:0] PCSE_OP_FPLS_LO = 6'h30;  // Float load/store range start
  localparam logic [5:0] PCSE_OP_FPLS_HI = 6'h37;  // Float load/store range end
  localparam logic [5:0] PCSE_OP_FPS     = 6'h3b;  // Single-precision arithmetic
  localparam logic [5:0] PCSE_OP_FPD     = 6'h3f;  // Double-precision arithmetic
  localparam logic [9:0] PCSE_XO_MCRXR   = 10'h200;
  localparam logic [9:0] PCSE_XO_MFCR    = 10'h013;
  localparam logic [9:0] PCSE_XO_MTCRF   = 10'h090;
  localparam logic [9:0] PCSE_XO_MFSPR   = 10'h153;
  localparam logic [9:0] PCSE_XO_MTSPR   = 10'h1d3;
  localparam logic [9:0] PCSE_XO_IOBAR   = 10'h356;
  localparam logic [9:0] PCSE_XO_SYNC    = 10'h256;
  localparam logic [9:0] PCSE_XO_ISYNC   = 10'h096;
  // Instruction field positions
  localparam int PCSE_OP_MSB   = 31;
  localparam int PCSE_RD_MSB   = 25;
  localparam int PCSE_CRF_MSB  = 25;
  localparam int PCSE_CRM_MSB  = 19;
  localparam int PCSE_SPRA_MSB = 20;
  localparam int PCSE_SPRB_MSB = 15;
  localparam int PCSE_XO_MSB   = 10;
  // Fixed-point exception register summary bits 0:3
  localparam int PCSE_XER_SUM_MSB = 31;
  localparam logic [9:0]  PCSE_SPR_XER    = 10'h001;
  localparam logic [31:0] PCSE_XER_RESET  = 32'h0000_0000;
  localparam logic [31:0] PCSE_CR_RESET   = 32'h0000_0000;
  localparam logic [15:0] PCSE_VEC_PROG   = 16'h0700;
  // Synchronizer sequencing, Gray along idle-wait-flush
  typedef enum logic [1:0] {
    PCSE_IDLE  = 2'b00,
    PCSE_WAIT  = 2'b01,
    PCSE_FLUSH = 2'b11
  } pcse_state_t;
endpackage

// ==== verification/pcse_far_model.sv ====
// Far-side model: pipeline drain, memory quiescence and the SPR file.
// Assumes the unit's clock and reset; drain waits reload whenever i_arm toggles.
`timescale 1ns/1ns
module pcse_far_model (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_arm,
  input  wire logic [7:0]  i_pipe_wait,
  input  wire logic [7:0]  i_mem_wait,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_spr_we,
  input  wire logic [9:0]  i_spr_num,
  input  wire logic [31:0] i_spr_wdata,
  output logic             o_pipe_empty,
  output logic             o_mem_idle,
  output logic [31:0]      o_spr_rdata
);
  logic [7:0]  pipe_cnt_r;
  logic [7:0]  mem_cnt_r;
  logic        arm_r;
  logic [31:0] spr_file [1024];
  // Earlier work drains one count per cycle; memory may outlast the pipeline
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pipe_cnt_r <= 8'h00;
      mem_cnt_r  <= 8'h00;
      arm_r      <= 1'b0;
    end else begin
      arm_r      <= i_arm;
      pipe_cnt_r <= (i_arm != arm_r) ? i_pipe_wait : pipe_cnt_r - 8'(pipe_cnt_r != 8'h00);
      mem_cnt_r  <= (i_arm != arm_r) ? i_mem_wait : mem_cnt_r - 8'(mem_cnt_r != 8'h00);
    end
  end
  assign o_pipe_empty = (pipe_cnt_r == 8'h00);
  assign o_mem_idle   = (mem_cnt_r == 8'h00);
  // Split number: low half sits in the higher instruction slice
  assign o_spr_rdata = spr_file[{i_instr[15:11], i_instr[20:16]}];
  // Distinct pattern per number so a wrong index shows up
  initial begin
    for (int k = 0; k < 1024; k++) begin
      spr_file[k] = 32'ha5a5_0000 ^ 32'(k);
    end
  end
  always @(posedge i_mclk) begin
    if (i_spr_we) begin
      spr_file[i_spr_num] <= i_spr_wdata;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the processor-control and synchronizing unit.
// Assumes the far-side model answers SPR reads and drain status on the same clock.
`timescale 1ns/1ns
module tb_top;
  import pcse_pkg::*;
  logic        i_mclk, i_resetn, i_valid, i_pipe_empty, i_mem_idle, arm;
  logic [31:0] i_instr, i_source_gpr, i_spr_rdata, exp_cr, xs;
  logic        o_ready, o_gpr_we, o_spr_we, o_prog_int, o_flush_prefetch, o_sync_done;
  logic [31:0] o_condition_register, o_fixed_point_exception_reg, o_gpr_wdata, o_spr_wdata;
  logic [4:0]  o_gpr_addr;
  logic [9:0]  o_spr_num;
  logic [15:0] o_int_vector;
  logic [7:0]  pipe_wait, mem_wait, masks [6];
  int          fail_count, compares, n_sync, n_bar;
  int          cyc = 0;
  pcse_exec u_dut (.i_mclk, .i_resetn, .i_valid, .i_instr, .i_source_gpr, .i_spr_rdata, .i_pipe_empty,
    .i_mem_idle, .o_ready, .o_condition_register, .o_fixed_point_exception_reg, .o_gpr_we, .o_gpr_addr,
    .o_gpr_wdata, .o_spr_we, .o_spr_num, .o_spr_wdata, .o_prog_int, .o_int_vector, .o_flush_prefetch,
    .o_sync_done);
  pcse_far_model u_far (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_arm(arm), .i_pipe_wait(pipe_wait),
    .i_mem_wait(mem_wait), .i_instr(i_instr), .i_spr_we(o_spr_we), .i_spr_num(o_spr_num),
    .i_spr_wdata(o_spr_wdata), .o_pipe_empty(i_pipe_empty), .o_mem_idle(i_mem_idle),
    .o_spr_rdata(i_spr_rdata));
  always #10 i_mclk = ~i_mclk;
  // Hang guard, far above the roughly 120 cycles the sequence needs
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xf(input logic [4:0] a, b, c, input logic [9:0] xo);
    return {PCSE_OP_EXT31, a, b, c, xo, 1'b0};
  endfunction
  // Split-field encoding of a special register number
  function automatic logic [31:0] spr_op(input logic [4:0] r, input logic [9:0] num, input logic [9:0] xo);
    return xf(r, num[4:0], num[9:5], xo);
  endfunction
  // Offer at a falling edge once ready; results are checked at the next falling edge, half a cycle after the take
  task automatic issue(input logic [31:0] ins, input logic [31:0] src);
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_ready !== 1'b1 && n < 50) begin
      @(negedge i_mclk);
      n++;
    end
    i_valid = 1'b1;
    i_instr = ins;
    i_source_gpr = src;
    @(negedge i_mclk);
    i_valid = 1'b0;
  endtask
  task automatic sync_run(input logic [9:0] xo, input logic [7:0] pw, mw, input logic isy, output int n);
    logic fl;
    @(negedge i_mclk);
    pipe_wait = pw;
    mem_wait = mw;
    arm = ~arm;
    // Instruction synchronize sits under the other primary opcode
    issue({isy ? PCSE_OP_EXT19 : PCSE_OP_EXT31, 15'h0000, xo, 1'b0}, 32'h0);
    chk_bit(o_ready, 1'b0);
    fl = 1'b0;
    n = 0;
    while (o_sync_done !== 1'b1 && n < 60) begin
      fl = fl | o_flush_prefetch;
      @(negedge i_mclk);
      n++;
    end
    chk_bit(o_sync_done, 1'b1);
    chk_bit(i_pipe_empty, 1'b1);
    chk_bit(i_mem_idle, !isy);
    if (isy) begin
      chk_bit(fl, 1'b1);
    end
  endtask
  initial begin
    i_mclk = 0; i_resetn = 0; i_valid = 0; i_instr = 0; i_source_gpr = 0; arm = 0;
    pipe_wait = 0; mem_wait = 0; fail_count = 0; compares = 0; exp_cr = 0;
    masks = '{8'h64, 8'hff, 8'h00, 8'h81, 8'h18, 8'h80};
    repeat (16) @(negedge i_mclk);
    i_resetn = 1;
    chk_word(o_condition_register, 32'h0);
    chk_word({16'h0, o_int_vector}, 32'h0000_0700);
    // Masked writes: each mask bit steers one field, top bit field 0
    for (int k = 0; k < 6; k++) begin
      xs = 32'h1357_9bdf ^ {8{4'(k)}};
      issue(xf(5'h03, {1'b0, masks[k][7:4]}, {masks[k][3:0], 1'b0}, PCSE_XO_MTCRF), xs);
      for (int f = 0; f < 8; f++) if (masks[k][7-f]) exp_cr[31-4*f -: 4] = xs[31-4*f -: 4];
      chk_word(o_condition_register, exp_cr);
    end
    issue(xf(5'h09, 5'h00, 5'h00, PCSE_XO_MFCR), 32'h0);
    chk_bit(o_gpr_we, 1'b1);
    chk_word({27'h0, o_gpr_addr}, 32'h9);
    chk_word(o_gpr_wdata, exp_cr);
    // Asymmetric number exposes swapped halves
    issue(spr_op(5'h04, 10'h2c3, PCSE_XO_MTSPR), 32'hdead_0001);
    chk_bit(o_spr_we, 1'b1);
    chk_word({22'h0, o_spr_num}, 32'h2c3);
    chk_word(o_spr_wdata, 32'hdead_0001);
    issue(spr_op(5'h07, 10'h2c3, PCSE_XO_MFSPR), 32'h0);
    chk_word(o_gpr_wdata, 32'hdead_0001);
    issue(spr_op(5'h07, 10'h011, PCSE_XO_MFSPR), 32'h0);
    chk_word(o_gpr_wdata, 32'ha5a5_0011);
    // Summary move into every field, each with fresh summary bits
    for (int f = 0; f < 8; f++) begin
      xs = {4'(15 - f), 28'h00000a5};
      issue(spr_op(5'h02, PCSE_SPR_XER, PCSE_XO_MTSPR), xs);
      chk_word(o_fixed_point_exception_reg, xs);
      issue(xf({f[2:0], 2'b00}, 5'h00, 5'h00, PCSE_XO_MCRXR), 32'h0);
      exp_cr[31-4*f -: 4] = xs[31:28];
      chk_word(o_condition_register, exp_cr);
      chk_word(o_fixed_point_exception_reg, 32'h0000_00a5);
    end
    issue(spr_op(5'h01, PCSE_SPR_XER, PCSE_XO_MFSPR), 32'h0);
    chk_word(o_gpr_wdata, 32'h0000_00a5);
    // Every float opcode traps and leaves the condition register alone
    for (int k = 0; k < 10; k++) begin
      issue({(k < 8) ? 6'(48 + k) : ((k == 8) ? PCSE_OP_FPS : PCSE_OP_FPD), 26'h155_aaaa}, 32'hffff_ffff);
      chk_bit(o_prog_int, 1'b1);
      chk_word(o_condition_register, exp_cr);
    end
    sync_run(PCSE_XO_SYNC, 8'd4, 8'd9, 1'b0, n_sync);
    sync_run(PCSE_XO_IOBAR, 8'd4, 8'd9, 1'b0, n_bar);
    chk_word(32'(n_bar), 32'(n_sync));
    sync_run(PCSE_XO_ISYNC, 8'd3, 8'd40, 1'b1, n_bar);
    end_of_test();
  end
endmodule
